/* File: rtl/dacc_top.sv */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module dacc_top
  import dacc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic      [7:0]  ch0_conv_code,
  output logic      [7:0]  ch1_conv_code,
  output logic             ch0_conv_run,
  output logic             ch1_conv_run,
  output logic             ch0_conv_start,
  output logic             ch1_conv_start,
  output logic             channel0_pin_enable,
  output logic             channel1_pin_enable,
  output logic             converter_halted
);
  logic [15:0] module_halt_control_ff;
  logic [7:0]  channel0_output_code_ff;
  logic [7:0]  channel1_output_code_ff;
  logic [2:0]  ctrl_bits_ff;
  logic [15:0] rdata_ff;
  logic [7:0]  converter_output_control;
  logic        converter_halt_bit;
  logic        acc_ok;
  logic        wr_code0;
  logic        wr_code1;
  logic        wr_ctrl;
  logic        conv0_en;
  logic        conv1_en;
  logic        joint_conversion_select;

  dacc_ch_if ch0_if ();
  dacc_ch_if ch1_if ();

  // address match helper, used by both write and read decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // halt register stays reachable so software can wake the converter
  assign converter_halt_bit = module_halt_control_ff[HALT_BIT];
  assign acc_ok   = !converter_halt_bit;
  assign wr_code0 = reg_wr && acc_ok && hit(reg_addr, CODE0_OFS);
  assign wr_code1 = reg_wr && acc_ok && hit(reg_addr, CODE1_OFS);
  assign wr_ctrl  = reg_wr && acc_ok && hit(reg_addr, CTRL_OFS);

  // shared stop register; hardware standby reinitialises it, software standby not
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || hw_standby)
      module_halt_control_ff <= HALT_RST;
    else if (clk_en && reg_wr && hit(reg_addr, HALT_OFS))
      module_halt_control_ff <= reg_wdata;
  end

  // code registers; sw_standby deliberately has no effect here, so outputs hold
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || hw_standby)
    begin
      channel0_output_code_ff <= CODE_RST;
      channel1_output_code_ff <= CODE_RST;
    end
    else if (clk_en)
    begin
      if (wr_code0)
        channel0_output_code_ff <= reg_wdata[7:0];
      if (wr_code1)
        channel1_output_code_ff <= reg_wdata[7:0];
    end
  end

  // only the three writable control bits are stored
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || hw_standby)
      ctrl_bits_ff <= CTRL_RST[7:5];
    else if (clk_en && wr_ctrl)
      ctrl_bits_ff <= reg_wdata[7:5];
  end

  assign converter_output_control = {ctrl_bits_ff, CTRL_RO_ONES[4:0]};
  assign channel1_pin_enable      = converter_output_control[CH1_EN_BIT] && acc_ok;
  assign channel0_pin_enable      = converter_output_control[CH0_EN_BIT] && acc_ok;
  assign joint_conversion_select  = converter_output_control[JOINT_BIT];

  // joint mode widens conversion, never the pins
  always_comb
  begin
    if (!channel0_pin_enable && !channel1_pin_enable)
    begin
      conv0_en = 1'b0;
      conv1_en = 1'b0;
    end
    else if (joint_conversion_select)
    begin
      conv0_en = 1'b1;
      conv1_en = 1'b1;
    end
    else
    begin
      conv0_en = channel0_pin_enable;
      conv1_en = channel1_pin_enable;
    end
  end

  // read port: data valid only the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      rdata_ff <= 16'h0000;
    else if (clk_en)
    begin
      if (!reg_rd)
        rdata_ff <= 16'h0000;
      else if (hit(reg_addr, HALT_OFS))
        rdata_ff <= module_halt_control_ff;
      else if (!acc_ok)
        rdata_ff <= 16'h0000;
      else if (hit(reg_addr, CODE0_OFS))
        rdata_ff <= {8'h00, channel0_output_code_ff};
      else if (hit(reg_addr, CODE1_OFS))
        rdata_ff <= {8'h00, channel1_output_code_ff};
      else if (hit(reg_addr, CTRL_OFS))
        rdata_ff <= {8'h00, converter_output_control};
      else
        rdata_ff <= {8'h00, UNMAPPED_DATA};
    end
  end
  assign reg_rdata        = rdata_ff;
  assign converter_halted = converter_halt_bit;

  // bundle each channel toward its stage
  assign ch0_if.code    = channel0_output_code_ff;
  assign ch0_if.code_wr = wr_code0;
  assign ch0_if.conv_en = conv0_en;
  assign ch0_if.pin_en  = channel0_pin_enable;
  assign ch1_if.code    = channel1_output_code_ff;
  assign ch1_if.code_wr = wr_code1;
  assign ch1_if.conv_en = conv1_en;
  assign ch1_if.pin_en  = channel1_pin_enable;

  dacc_channel u_ch0 (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .ch         (ch0_if.dst),
    .conv_code  (ch0_conv_code),
    .conv_run   (ch0_conv_run),
    .pin_drive  (),
    .conv_start (ch0_conv_start)
  );

  dacc_channel u_ch1 (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .ch         (ch1_if.dst),
    .conv_code  (ch1_conv_code),
    .conv_run   (ch1_conv_run),
    .pin_drive  (),
    .conv_start (ch1_conv_start)
  );

  // checks
  code_reset_a : assert property (@(posedge core_clk)
    (sys_rst || hw_standby) |=> channel0_output_code_ff == 8'h00 && channel1_output_code_ff == 8'h00)
    else $error("code not cleared");
  ctrl_reset_a : assert property (@(posedge core_clk)
    (sys_rst || hw_standby) |=> converter_output_control == 8'h1f) else $error("control reset wrong");
  ch1_gate_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    channel1_pin_enable |-> ctrl_bits_ff[2]) else $error("ch1 pin without bit 7");
  ch0_gate_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    channel0_pin_enable |-> ctrl_bits_ff[1]) else $error("ch0 pin without bit 6");
  joint_both_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (joint_conversion_select && (channel0_pin_enable || channel1_pin_enable)) |-> (conv0_en && conv1_en))
    else $error("joint mode not both");
  both_off_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (!channel0_pin_enable && !channel1_pin_enable) |-> !(conv0_en || conv1_en))
    else $error("conversion while both disabled");
  solo_ch0_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (!joint_conversion_select && channel0_pin_enable && !channel1_pin_enable) |-> (conv0_en && !conv1_en))
    else $error("solo ch0 gating wrong");
  swstby_hold_a : assert property (@(posedge core_clk) disable iff (sys_rst || hw_standby)
    (sw_standby && !reg_wr) |=> $stable(channel0_output_code_ff) && $stable(ctrl_bits_ff))
    else $error("state lost in software standby");
  ro_ones_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    converter_output_control[4:0] == 5'h1f) else $error("low bits not ones");
  write_start_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && wr_code0) |=> ch0_conv_start) else $error("write did not start");
  halt_block_a : assert property (@(posedge core_clk) disable iff (sys_rst || hw_standby)
    (converter_halt_bit && reg_wr && clk_en) |=> $stable(channel1_output_code_ff))
    else $error("write while halted");
endmodule : dacc_top
`default_nettype wire

/* File: rtl/dacc_pkg.sv */
package dacc_pkg;
  // register offsets (low 16 bits of the address)
  localparam logic [15:0] HALT_OFS      = 16'hff3c;
  localparam logic [15:0] CODE0_OFS     = 16'hffa4;
  localparam logic [15:0] CODE1_OFS     = 16'hffa5;
  localparam logic [15:0] CTRL_OFS      = 16'hffa6;
  // reset values
  localparam logic [15:0] HALT_RST      = 16'h3fff;
  localparam logic [7:0]  CODE_RST      = 8'h00;
  localparam logic [7:0]  CTRL_RST      = 8'h1f;
  // control field positions
  localparam int          CH1_EN_BIT    = 7;
  localparam int          CH0_EN_BIT    = 6;
  localparam int          JOINT_BIT     = 5;
  localparam logic [7:0]  CTRL_RO_ONES  = 8'h1f;
  localparam logic [7:0]  CTRL_WR_MASK  = 8'he0;
  // halt bit position in the shared stop register
  localparam int          HALT_BIT      = 10;
  localparam logic [7:0]  UNMAPPED_DATA = 8'h00;
endpackage : dacc_pkg

/* File: rtl/dacc_ch_if.sv */
`timescale 1ns/100ps
`default_nettype none
// per-channel control bundle between the register block and the channel stage
interface dacc_ch_if;
  logic [7:0] code;
  logic       code_wr;
  logic       conv_en;
  logic       pin_en;
  modport src (output code, output code_wr, output conv_en, output pin_en);
  modport dst (input code, input code_wr, input conv_en, input pin_en);
endinterface : dacc_ch_if
`default_nettype wire

/* File: rtl/dacc_channel.sv */
`timescale 1ns/100ps
`default_nettype none
// one conversion channel: latches the code for the converter and gates the pin
module dacc_channel
  import dacc_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  sys_rst,
  input  wire logic  clk_en,
  dacc_ch_if.dst     ch,
  output logic [7:0] conv_code,
  output logic       conv_run,
  output logic       pin_drive,
  output logic       conv_start
);
  logic [7:0] code_ff;
  logic       run_ff;
  logic       pin_ff;
  logic       start_ff;

  // code follows the register so each write reaches the converter
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      code_ff  <= 8'h00;
      run_ff   <= 1'b0;
      pin_ff   <= 1'b0;
      start_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      code_ff  <= ch.code;
      run_ff   <= ch.conv_en;
      pin_ff   <= ch.pin_en;
      start_ff <= ch.code_wr || (ch.conv_en && !run_ff);
    end
  end

  assign conv_code  = code_ff;
  assign conv_run   = run_ff;
  assign pin_drive  = pin_ff;
  assign conv_start = start_ff;

  // a driven pin always has its converter running
  pin_needs_run_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    pin_drive |-> conv_run) else $error("pin driven without conversion");
  code_follow_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en |=> conv_code == $past(ch.code)) else $error("code not forwarded");
endmodule : dacc_channel
`default_nettype wire

/* File: sim/dacc_analog_model.sv */
`timescale 1ns/100ps
`default_nettype none
// far-side analog channel: holds the last converted code on its pin while the pin is driven
module dacc_analog_model
(
  input  wire logic       core_clk,
  input  wire logic [7:0] conv_code,
  input  wire logic       conv_run,
  input  wire logic       pin_drive,
  output logic      [7:0] pin_level
);
  logic [7:0] held_ff;
  // the converter only follows the code while the channel runs
  always_ff @(posedge core_clk)
  begin
    if (conv_run)
      held_ff <= conv_code;
  end
  // an undriven pin floats, so show the inverse rather than a stale value
  assign pin_level = pin_drive ? held_ff : ~held_ff;
endmodule : dacc_analog_model
`default_nettype wire

/* File: sim/dacc_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module dacc_top_tb;
  import dacc_pkg::*;
  logic        core_clk, sys_rst, clk_en, hw_standby, sw_standby, reg_wr, reg_rd;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic [7:0]  ch0_conv_code, ch1_conv_code, pin0_level, pin1_level;
  logic        ch0_conv_run, ch1_conv_run, ch0_conv_start, ch1_conv_start;
  logic        channel0_pin_enable, channel1_pin_enable, converter_halted;
  logic [2:0]  sel;
  int          mismatches, num_checks;

  dacc_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ch0_conv_code(ch0_conv_code), .ch1_conv_code(ch1_conv_code),
    .ch0_conv_run(ch0_conv_run), .ch1_conv_run(ch1_conv_run), .ch0_conv_start(ch0_conv_start),
    .ch1_conv_start(ch1_conv_start), .channel0_pin_enable(channel0_pin_enable),
    .channel1_pin_enable(channel1_pin_enable), .converter_halted(converter_halted));
  dacc_analog_model u_an0 (.core_clk(core_clk), .conv_code(ch0_conv_code), .conv_run(ch0_conv_run),
    .pin_drive(channel0_pin_enable), .pin_level(pin0_level));
  dacc_analog_model u_an1 (.core_clk(core_clk), .conv_code(ch1_conv_code), .conv_run(ch1_conv_run),
    .pin_drive(channel1_pin_enable), .pin_level(pin1_level));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one-cycle write strobe, released at the taking edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [15:0] a, input logic [15:0] exp, input string what);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask : rdc

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // watchdog: the sequence needs well under 1000 cycles
  initial
  begin
    #100000;
    mismatches++;
    end_of_test();
  end

  initial
  begin
    {hw_standby, sw_standby, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    sys_rst = 1'b1;
    clk_en  = 1'b1;
    mismatches = 0;
    num_checks = 0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    // out of reset the block is halted and refuses access
    rdc(HALT_OFS, HALT_RST, "halt reg");
    chk("halted", {15'h0000, converter_halted}, 16'h0001);
    wr(CODE0_OFS, 16'h00a5);
    rdc(CODE0_OFS, 16'h0000, "code0 halted");
    wr(HALT_OFS, 16'h3bff);
    rdc(CODE0_OFS, {8'h00, CODE_RST}, "code0 reset");
    rdc(CODE1_OFS, {8'h00, CODE_RST}, "code1 reset");
    rdc(CTRL_OFS, {8'h00, CTRL_RST}, "ctrl reset");
    rdc(16'hff00, 16'h0000, "unmapped");
    $display("test reset done");
    // code write starts conversion and reaches the converter
    wr(CODE0_OFS, 16'h0055);
    #1;
    chk("start0", {15'h0000, ch0_conv_start}, 16'h0001);
    @(posedge core_clk);
    #1;
    chk("conv code0", {8'h00, ch0_conv_code}, 16'h0055);
    wr(CODE1_OFS, 16'h00aa);
    #1;
    chk("start1", {15'h0000, ch1_conv_start}, 16'h0001);
    rdc(CODE0_OFS, 16'h0055, "code0");
    chk("conv code1", {8'h00, ch1_conv_code}, 16'h00aa);
    rdc(CODE1_OFS, 16'h00aa, "code1");
    // a frozen clock enable must swallow the write
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(CODE1_OFS, 16'h0011);
    clk_en <= 1'b1;
    rdc(CODE1_OFS, 16'h00aa, "code1 frozen");
    $display("test codes done");
    // every combination of the two enables and the joint bit
    for (int i = 0; i < 8; i++)
    begin
      sel = i[2:0];
      wr(CTRL_OFS, {8'h00, sel, 5'h00});
      repeat (2) @(posedge core_clk);
      #1;
      chk("pin0", {15'h0000, channel0_pin_enable}, {15'h0000, sel[1]});
      chk("pin1", {15'h0000, channel1_pin_enable}, {15'h0000, sel[2]});
      chk("run0", {15'h0000, ch0_conv_run}, {15'h0000, sel[1] | (sel[0] & sel[2])});
      chk("run1", {15'h0000, ch1_conv_run}, {15'h0000, sel[2] | (sel[0] & sel[1])});
      rdc(CTRL_OFS, {8'h00, sel, 5'h1f}, "ctrl");
    end
    chk("pin0 level", {8'h00, pin0_level}, 16'h0055);
    chk("pin1 level", {8'h00, pin1_level}, 16'h00aa);
    $display("test control done");
    // software standby keeps everything
    sw_standby <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdc(CTRL_OFS, 16'h00ff, "ctrl sw stby");
    rdc(CODE0_OFS, 16'h0055, "code0 sw stby");
    sw_standby <= 1'b0;
    // halting drops the pins and blocks reads
    wr(HALT_OFS, 16'h3fff);
    #1;
    chk("pins halted", {14'h0000, channel1_pin_enable, channel0_pin_enable}, 16'h0000);
    chk("halted again", {15'h0000, converter_halted}, 16'h0001);
    rdc(CTRL_OFS, 16'h0000, "ctrl halted");
    wr(HALT_OFS, 16'h3bff);
    // hardware standby reinitialises like reset
    @(posedge core_clk);
    hw_standby <= 1'b1;
    @(posedge core_clk);
    hw_standby <= 1'b0;
    rdc(HALT_OFS, HALT_RST, "halt hw stby");
    wr(HALT_OFS, 16'h3bff);
    rdc(CODE0_OFS, 16'h0000, "code0 hw stby");
    rdc(CTRL_OFS, 16'h001f, "ctrl hw stby");
    $display("test standby done");
    end_of_test();
  end
endmodule : dacc_top_tb
`default_nettype wire
